//--- design/ocd_map.vh
`ifndef OCD_MAP_VH
`define OCD_MAP_VH

// Register indices; byte address is four times the index
`define OCD_IDX_REF_ROUTE   10'h019
`define OCD_IDX_PRESCALER   10'h02f
`define OCD_IDX_CHANNEL_DIVIDE_RATIO     10'h038
`define OCD_IDX_CH1_SE      10'h03b
`define OCD_IDX_CH1_SLEW    10'h03c
`define OCD_IDX_CH2_DIV     10'h03e
`define OCD_IDX_CH3_DIV     10'h043
`define OCD_IDX_CH4_DIV     10'h048
`define OCD_IDX_CH4_SE      10'h04b
`define OCD_IDX_CH4_SLEW    10'h04c
`define OCD_IDX_OUTPUT_ZERO_EN     10'h04e
`define OCD_IDX_OUTPUT_ZERO_SLEW   10'h04f
`define OCD_IDX_DIST_CTRL   10'h050
`define OCD_IDX_STATUS      10'h051

// Reset value of every writable register
`define OCD_REG_RESET       16'h0000

// Field positions
`define OCD_PSB_LSB         5
`define OCD_PSA_LSB         3
`define OCD_DIV_MSB         13
`define OCD_SEL_LSB         14
`define OCD_BYPASS_LSB      11
`define OCD_OUTPUT_ZERO_ROUTE_BIT  10
`define OCD_OUTPUT_ZERO_SRC_BIT    9
`define OCD_OUTPUT_ZERO_BUF_BIT    12
`define OCD_SE_EN_HI_BIT    14
`define OCD_SE_EN_LO_BIT    13
`define OCD_SE_POL_HI_BIT   12
`define OCD_SE_POL_LO_BIT   11
`define OCD_HCSL_LSB        0
`define OCD_LVDS_LSB        4
`define OCD_DETECT_LSB      8
`define OCD_SAFETY_BIT      12
`define OCD_SYNC_BIT        13

// Prescaler ratio codes and terminal counts
`define OCD_PS_DIV4         2'h0
`define OCD_PS_DIV5         2'h1
`define OCD_PS_DIV6         2'h2
`define OCD_PS_LAST4        3'h3
`define OCD_PS_LAST5        3'h4
`define OCD_PS_LAST6        3'h5

// Channel source selector codes
`define OCD_SRC_PSA         2'h0
`define OCD_SRC_PSB         2'h1
`define OCD_SRC_REF         2'h2
`define OCD_SRC_OFF         2'h3

`endif

//--- design/ocd_int_divider.v
`timescale 1ns/1ps
`include "ocd_map.vh"

module ocd_int_divider (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  // Source tick and control
  input  wire        srcTick,
  input  wire [13:0] ratio,
  input  wire        holdSync,
  // Divided clock level
  output wire        divClk
);

  reg  [13:0] pos_ff;
  reg  [13:0] nxt_pos;
  reg  [13:0] ratio_ff;
  reg  [13:0] nxt_ratio;
  reg         out_ff;
  reg         nxt_out;
  wire [13:0] curRatio;
  wire [13:0] effRatio;
  wire [13:0] highLen;

  // New ratio only takes hold at a period start, so no high phase is cut short
  assign curRatio = (pos_ff == 14'h0000) ? ratio : ratio_ff;
  assign effRatio = (curRatio == 14'h0000) ? 14'h0001 : curRatio;
  assign highLen  = {1'b0, effRatio[13:1]} + {13'h0000, effRatio[0]};
  assign divClk   = out_ff;

  // Position within the period; ratio one degenerates to a pulse per tick
  always @*
  begin
    nxt_pos   = pos_ff;
    nxt_ratio = ratio_ff;
    nxt_out   = out_ff;
    if (holdSync)
    begin
      nxt_pos = 14'h0000;
      nxt_out = 1'b0;
    end
    else if (srcTick)
    begin
      nxt_ratio = curRatio;
      nxt_out   = (pos_ff < highLen);
      if (pos_ff >= effRatio - 14'h0001)
        nxt_pos = 14'h0000;
      else
        nxt_pos = pos_ff + 14'h0001;
    end
    else if (effRatio == 14'h0001)
    begin
      nxt_out = 1'b0;
    end
  end

  // State registers
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pos_ff   <= 14'h0000;
      ratio_ff <= 14'h0000;
      out_ff   <= 1'b0;
    end
    else
    begin
      pos_ff   <= nxt_pos;
      ratio_ff <= nxt_ratio;
      out_ff   <= nxt_out;
    end
  end

endmodule // ocd_int_divider

//--- design/ocd_top.v
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "ocd_map.vh"

module ocd_top (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  // APB slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Clock sources
  input  wire        vcoTick,
  input  wire        refClkPin,
  input  wire        pfdClkPin,
  // Output zero
  output wire        outZeroClk,
  output wire [3:0]  outZeroSlewSetting,
  // Differential channel outputs
  output wire [3:0]  chDiffClk,
  output wire [3:0]  chHcslEnable,
  output wire [3:0]  chLvdsEnable,
  // Single-ended pins of channels 1 and 4
  output wire        ch1PinP,
  output wire        ch1PinN,
  output wire        ch4PinP,
  output wire        ch4PinN,
  output wire [3:0]  ch1SlewSetting,
  output wire [3:0]  ch4SlewSetting,
  // Supply settings
  output wire [3:0]  chSupplyDetect,
  output wire        safetyLowVoltage
);

  // Register file
  reg  [15:0] refRoute_ff;
  reg  [15:0] prescaler_ff;
  reg  [15:0] ch1Div_ff;
  reg  [15:0] ch1Se_ff;
  reg  [15:0] ch1Slew_ff;
  reg  [15:0] ch2Div_ff;
  reg  [15:0] ch3Div_ff;
  reg  [15:0] ch4Div_ff;
  reg  [15:0] ch4Se_ff;
  reg  [15:0] ch4Slew_ff;
  reg  [15:0] out0En_ff;
  reg  [15:0] out0Slew_ff;
  reg  [15:0] distCtrl_ff;

  // Bus answer registers
  reg  [31:0] prdata_ff;
  reg  [31:0] nxt_prdata;
  reg         pready_ff;
  reg         pslverr_ff;
  reg         nxt_pslverr;
  reg         hit;

  // Clock input conditioning
  reg  [2:0]  refSync_ff;
  reg  [2:0]  pfdSync_ff;
  reg         refLvl_ff;
  reg         pfdLvl_ff;
  reg         refLvlDly_ff;

  // Prescalers
  reg  [2:0]  psaCnt_ff;
  reg  [2:0]  psbCnt_ff;
  reg         psaTick_ff;
  reg         psbTick_ff;

  // Output registers
  reg         outZero_ff;
  reg  [3:0]  chClk_ff;
  reg  [3:0]  chDiff_ff;
  reg         ch1P_ff;
  reg         ch1N_ff;
  reg         ch4P_ff;
  reg         ch4N_ff;

  wire [9:0]  regIdx;
  wire        setupPhase;
  wire        wrEn;
  wire        refTick;
  wire [63:0] chCtrl;
  wire [3:0]  divClk;
  wire [3:0]  chLevel;
  wire [2:0]  psaLast;
  wire [2:0]  psbLast;
  wire        psaRun;
  wire        psbRun;

  assign regIdx     = paddr[11:2];
  assign setupPhase = psel & ~penable;
  assign wrEn       = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  // Read decode in setup phase; answer lands with one wait-free access phase
  always @*
  begin
    hit        = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (regIdx)
      `OCD_IDX_REF_ROUTE: nxt_prdata[15:0] = refRoute_ff;
      `OCD_IDX_PRESCALER: nxt_prdata[15:0] = prescaler_ff;
      `OCD_IDX_CHANNEL_DIVIDE_RATIO:   nxt_prdata[15:0] = ch1Div_ff;
      `OCD_IDX_CH1_SE:    nxt_prdata[15:0] = ch1Se_ff;
      `OCD_IDX_CH1_SLEW:  nxt_prdata[15:0] = ch1Slew_ff;
      `OCD_IDX_CH2_DIV:   nxt_prdata[15:0] = ch2Div_ff;
      `OCD_IDX_CH3_DIV:   nxt_prdata[15:0] = ch3Div_ff;
      `OCD_IDX_CH4_DIV:   nxt_prdata[15:0] = ch4Div_ff;
      `OCD_IDX_CH4_SE:    nxt_prdata[15:0] = ch4Se_ff;
      `OCD_IDX_CH4_SLEW:  nxt_prdata[15:0] = ch4Slew_ff;
      `OCD_IDX_OUTPUT_ZERO_EN:   nxt_prdata[15:0] = out0En_ff;
      `OCD_IDX_OUTPUT_ZERO_SLEW: nxt_prdata[15:0] = out0Slew_ff;
      `OCD_IDX_DIST_CTRL: nxt_prdata[15:0] = distCtrl_ff;
      `OCD_IDX_STATUS:    nxt_prdata[15:0] = {6'h00, refLvl_ff, outZero_ff, chDiff_ff, chClk_ff};
      default:            hit = 1'b0;
    endcase
    if (!hit || pwrite)
      nxt_prdata = 32'h0000_0000;
    nxt_pslverr = ~hit | (paddr[1:0] != 2'h0);
  end

  // Bus handshake; status register ignores writes without an error
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= setupPhase;
      pslverr_ff <= setupPhase & nxt_pslverr;
      prdata_ff  <= setupPhase ? nxt_prdata : 32'h0000_0000;
    end
  end

  // Register writes; only the low sixteen data bits are stored
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      refRoute_ff  <= `OCD_REG_RESET;
      prescaler_ff <= `OCD_REG_RESET;
      ch1Div_ff    <= `OCD_REG_RESET;
      ch1Se_ff     <= `OCD_REG_RESET;
      ch1Slew_ff   <= `OCD_REG_RESET;
      ch2Div_ff    <= `OCD_REG_RESET;
      ch3Div_ff    <= `OCD_REG_RESET;
      ch4Div_ff    <= `OCD_REG_RESET;
      ch4Se_ff     <= `OCD_REG_RESET;
      ch4Slew_ff   <= `OCD_REG_RESET;
      out0En_ff    <= `OCD_REG_RESET;
      out0Slew_ff  <= `OCD_REG_RESET;
      distCtrl_ff  <= `OCD_REG_RESET;
    end
    else if (wrEn)
    begin
      case (regIdx)
        `OCD_IDX_REF_ROUTE: refRoute_ff  <= pwdata[15:0];
        `OCD_IDX_PRESCALER: prescaler_ff <= pwdata[15:0];
        `OCD_IDX_CHANNEL_DIVIDE_RATIO:   ch1Div_ff    <= pwdata[15:0];
        `OCD_IDX_CH1_SE:    ch1Se_ff     <= pwdata[15:0];
        `OCD_IDX_CH1_SLEW:  ch1Slew_ff   <= pwdata[15:0];
        `OCD_IDX_CH2_DIV:   ch2Div_ff    <= pwdata[15:0];
        `OCD_IDX_CH3_DIV:   ch3Div_ff    <= pwdata[15:0];
        `OCD_IDX_CH4_DIV:   ch4Div_ff    <= pwdata[15:0];
        `OCD_IDX_CH4_SE:    ch4Se_ff     <= pwdata[15:0];
        `OCD_IDX_CH4_SLEW:  ch4Slew_ff   <= pwdata[15:0];
        `OCD_IDX_OUTPUT_ZERO_EN:   out0En_ff    <= pwdata[15:0];
        `OCD_IDX_OUTPUT_ZERO_SLEW: out0Slew_ff  <= pwdata[15:0];
        `OCD_IDX_DIST_CTRL: distCtrl_ff  <= pwdata[15:0];
        default:            distCtrl_ff  <= distCtrl_ff;
      endcase
    end
  end

  // Pin clocks pass three stages; a level counts once stages two and three agree
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      refSync_ff   <= 3'h0;
      pfdSync_ff   <= 3'h0;
      refLvl_ff    <= 1'b0;
      pfdLvl_ff    <= 1'b0;
      refLvlDly_ff <= 1'b0;
    end
    else
    begin
      refSync_ff   <= {refSync_ff[1:0], refClkPin};
      pfdSync_ff   <= {pfdSync_ff[1:0], pfdClkPin};
      refLvl_ff    <= (refSync_ff[1] == refSync_ff[2]) ? refSync_ff[2] : refLvl_ff;
      pfdLvl_ff    <= (pfdSync_ff[1] == pfdSync_ff[2]) ? pfdSync_ff[2] : pfdLvl_ff;
      refLvlDly_ff <= refLvl_ff;
    end
  end

  // Reference rising edge is the divider tick when reference is the source
  assign refTick = refLvl_ff & ~refLvlDly_ff;

  // Ratio code to terminal count; the spare code stops the prescaler
  function [2:0] psLast;
    input [1:0] code;
    begin
      case (code)
        `OCD_PS_DIV4: psLast = `OCD_PS_LAST4;
        `OCD_PS_DIV5: psLast = `OCD_PS_LAST5;
        `OCD_PS_DIV6: psLast = `OCD_PS_LAST6;
        default:      psLast = 3'h0;
      endcase
    end
  endfunction

  assign psaLast = psLast(prescaler_ff[`OCD_PSA_LSB +: 2]);
  assign psbLast = psLast(prescaler_ff[`OCD_PSB_LSB +: 2]);
  assign psaRun  = (psaLast != 3'h0);
  assign psbRun  = (psbLast != 3'h0);

  // Two independent prescalers count VCO ticks, one tick out per period
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      psaCnt_ff  <= 3'h0;
      psbCnt_ff  <= 3'h0;
      psaTick_ff <= 1'b0;
      psbTick_ff <= 1'b0;
    end
    else
    begin
      psaTick_ff <= psaRun & vcoTick & (psaCnt_ff == 3'h0);
      psbTick_ff <= psbRun & vcoTick & (psbCnt_ff == 3'h0);
      if (!psaRun)
        psaCnt_ff <= 3'h0;
      else if (vcoTick)
        psaCnt_ff <= (psaCnt_ff >= psaLast) ? 3'h0 : psaCnt_ff + 3'h1;
      if (!psbRun)
        psbCnt_ff <= 3'h0;
      else if (vcoTick)
        psbCnt_ff <= (psbCnt_ff >= psbLast) ? 3'h0 : psbCnt_ff + 3'h1;
    end
  end

  assign chCtrl = {ch4Div_ff, ch3Div_ff, ch2Div_ff, ch1Div_ff};

  // One divider per channel, fed by its own source selector
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : gChan
      wire [1:0] srcSel;
      wire       srcTick;
      wire       bypass;

      assign srcSel  = chCtrl[16*gi+`OCD_SEL_LSB +: 2];
      assign srcTick = (srcSel == `OCD_SRC_PSA) ? psaTick_ff :
                       (srcSel == `OCD_SRC_PSB) ? psbTick_ff :
                       (srcSel == `OCD_SRC_REF) ? refTick : 1'b0;
      assign bypass  = refRoute_ff[`OCD_BYPASS_LSB+gi];

      ocd_int_divider uDiv (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .srcTick  (srcTick),
        .ratio    (chCtrl[16*gi +: 14]),
        .holdSync (distCtrl_ff[`OCD_SYNC_BIT]),
        .divClk   (divClk[gi])
      );

      // Bypass hands the reference straight out; code three silences the channel
      assign chLevel[gi] = bypass ? refLvl_ff :
                           (srcSel == `OCD_SRC_OFF) ? 1'b0 : divClk[gi];
    end
  endgenerate

  // Output stage; everything leaving the block is a flop
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      outZero_ff <= 1'b0;
      chClk_ff   <= 4'h0;
      chDiff_ff  <= 4'h0;
      ch1P_ff    <= 1'b0;
      ch1N_ff    <= 1'b0;
      ch4P_ff    <= 1'b0;
      ch4N_ff    <= 1'b0;
    end
    else
    begin
      // Output zero needs both routing and its own buffer enable
      outZero_ff <= refRoute_ff[`OCD_OUTPUT_ZERO_ROUTE_BIT]
                    & out0En_ff[`OCD_OUTPUT_ZERO_BUF_BIT]
                    & (refRoute_ff[`OCD_OUTPUT_ZERO_SRC_BIT] ? refLvl_ff : pfdLvl_ff);
      chClk_ff   <= chLevel;
      // Differential copy runs whenever either differential buffer is on
      chDiff_ff  <= chLevel & (distCtrl_ff[`OCD_HCSL_LSB +: 4]
                               | distCtrl_ff[`OCD_LVDS_LSB +: 4]);
      // Channel 4 mirrors channel 1: high enable bit serves P there, N here
      ch1N_ff <= ch1Se_ff[`OCD_SE_EN_HI_BIT]
                 & (chLevel[0] ^ ch1Se_ff[`OCD_SE_POL_HI_BIT]);
      ch1P_ff <= ch1Se_ff[`OCD_SE_EN_LO_BIT]
                 & (chLevel[0] ^ ch1Se_ff[`OCD_SE_POL_LO_BIT]);
      ch4P_ff <= ch4Se_ff[`OCD_SE_EN_HI_BIT]
                 & (chLevel[3] ^ ch4Se_ff[`OCD_SE_POL_HI_BIT]);
      ch4N_ff <= ch4Se_ff[`OCD_SE_EN_LO_BIT]
                 & (chLevel[3] ^ ch4Se_ff[`OCD_SE_POL_LO_BIT]);
    end
  end

  // Port assignments; setting outputs come straight from register flops
  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
  assign outZeroClk         = outZero_ff;
  assign outZeroSlewSetting = out0Slew_ff[3:0];
  assign chDiffClk          = chDiff_ff;
  assign chHcslEnable       = distCtrl_ff[`OCD_HCSL_LSB +: 4];
  assign chLvdsEnable       = distCtrl_ff[`OCD_LVDS_LSB +: 4];
  assign ch1PinP            = ch1P_ff;
  assign ch1PinN            = ch1N_ff;
  assign ch4PinP            = ch4P_ff;
  assign ch4PinN            = ch4N_ff;
  assign ch1SlewSetting     = ch1Slew_ff[3:0];
  assign ch4SlewSetting     = ch4Slew_ff[3:0];
  assign chSupplyDetect     = distCtrl_ff[`OCD_DETECT_LSB +: 4];
  assign safetyLowVoltage   = distCtrl_ff[`OCD_SAFETY_BIT];

endmodule // ocd_top

//--- verification/ocd_top_assertions.sv
`timescale 1ns/1ps
module ocd_checker (
  // Clock and reset
  input wire        sys_clk,
  input wire        reset,
  // APB
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Sources
  input wire        vcoTick,
  input wire        refClkPin,
  input wire        pfdClkPin,
  // Outputs
  input wire        outZeroClk,
  input wire [3:0]  outZeroSlewSetting,
  input wire [3:0]  chDiffClk,
  input wire [3:0]  chHcslEnable,
  input wire [3:0]  chLvdsEnable,
  input wire        ch1PinP,
  input wire        ch1PinN,
  input wire        ch4PinP,
  input wire        ch4PinN,
  input wire [3:0]  chSupplyDetect,
  input wire        safetyLowVoltage
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  wire       wrDone = psel && penable && pready && pwrite && !pslverr;
  reg  [3:0] quietRef_ff;
  reg  [3:0] quietAll_ff;
  // Idle counters saturate at 8, well past the 3-flop synchroniser plus output stage
  wire [3:0] nxt_quietRef = (refClkPin || pfdClkPin) ? 4'h0 :
                            (quietRef_ff == 4'h8) ? 4'h8 : quietRef_ff + 4'h1;
  wire [3:0] nxt_quietAll = (vcoTick || refClkPin || pfdClkPin || psel) ? 4'h0 :
                            (quietAll_ff == 4'h8) ? 4'h8 : quietAll_ff + 4'h1;

  // Count idle cycles of the clock sources
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      quietRef_ff <= 4'h0;
      quietAll_ff <= 4'h0;
    end
    else
    begin
      quietRef_ff <= nxt_quietRef;
      quietAll_ff <= nxt_quietAll;
    end
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_one_wait;
    s_setup |=> s_access ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not a single access cycle");

  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");

  property p_rdata_upper;
    pready |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper half set");

  property p_err_unaligned;
    s_setup and paddr[1:0] != 2'b00 |=> pslverr && pready;
  endproperty
  a_err_unaligned: assert property (p_err_unaligned) else $error("misaligned not refused");

  property p_err_unmapped;
    s_setup and paddr[11:2] > 10'h051 |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");

  property p_output_zero_slew;
    !$stable(outZeroSlewSetting) |-> $past(wrDone) && $past(paddr) == 12'h13c &&
      outZeroSlewSetting == $past(pwdata[3:0]);
  endproperty
  a_output_zero_slew: assert property (p_output_zero_slew) else $error("slew moved without write");

  property p_enables;
    !$stable({chHcslEnable, chLvdsEnable, chSupplyDetect, safetyLowVoltage}) |->
      $past(wrDone) && $past(paddr) == 12'h140;
  endproperty
  a_enables: assert property (p_enables) else $error("buffer enables moved");

  property p_output_zero_quiet;
    quietRef_ff == 4'h8 |-> !outZeroClk;
  endproperty
  a_output_zero_quiet: assert property (p_output_zero_quiet) else $error("output zero without source");

  property p_hold;
    quietAll_ff == 4'h8 |-> $stable({chDiffClk, ch1PinP, ch1PinN, ch4PinP, ch4PinN});
  endproperty
  a_hold: assert property (p_hold) else $error("channel moved without tick");
endmodule // ocd_checker

bind ocd_top ocd_checker chk (.sys_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pready, .pslverr, .vcoTick, .refClkPin, .pfdClkPin, .outZeroClk,
  .outZeroSlewSetting, .chDiffClk, .chHcslEnable, .chLvdsEnable, .ch1PinP, .ch1PinN,
  .ch4PinP, .ch4PinN, .chSupplyDetect, .safetyLowVoltage);

//--- verification/output_clock_distribution_test.sv
`timescale 1ns/1ps
module output_clock_distribution_test;
  // Stimulus
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        vcoTick = 1'b0;
  logic        refClkPin = 1'b0;
  logic        pfdClkPin = 1'b0;
  logic        srcRun = 1'b0;
  logic [4:0]  srcPhase_ff = 5'h00;
  // Observed
  wire  [31:0] prdata;
  wire         pready, pslverr, outZeroClk, ch1PinP, ch1PinN, ch4PinP, ch4PinN, safetyLowVoltage;
  wire  [3:0]  outZeroSlewSetting, chDiffClk, chHcslEnable, chLvdsEnable;
  wire  [3:0]  ch1SlewSetting, ch4SlewSetting, chSupplyDetect;
  wire  [8:0]  obs = {outZeroClk, ch4PinN, ch4PinP, ch1PinN, ch1PinP, chDiffClk};
  integer      num_errors = 0;
  integer      tests_run = 0;
  integer      i, p;
  logic [31:0] rd;
  logic        err;
  logic [11:0] regAddr [0:12] = '{12'h064, 12'h0bc, 12'h0e0, 12'h0ec, 12'h0f0, 12'h0f8,
                                  12'h10c, 12'h120, 12'h12c, 12'h130, 12'h138, 12'h13c, 12'h140};

  always #25 sys_clk = ~sys_clk;

  // Reference has a 6-cycle period, PFD 10; both stay low until the paths are exercised
  always @(posedge sys_clk)
  begin
    srcPhase_ff <= (srcPhase_ff == 5'h1d) ? 5'h00 : srcPhase_ff + 5'h01;
    refClkPin <= srcRun && (srcPhase_ff % 6 < 3);
    pfdClkPin <= srcRun && (srcPhase_ff % 10 < 5);
  end

  ocd_top uut (.sys_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .vcoTick, .refClkPin, .pfdClkPin, .outZeroClk, .outZeroSlewSetting, .chDiffClk,
    .chHcslEnable, .chLvdsEnable, .ch1PinP, .ch1PinN, .ch4PinP, .ch4PinN, .ch1SlewSetting,
    .ch4SlewSetting, .chSupplyDetect, .safetyLowVoltage);

  task final_report;
    begin
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    begin
      tests_run++;
      if (got !== expv)
      begin
        $display("mismatch %s expected %h seen %h", what, expv, got);
        num_errors++;
      end
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task xfer(input logic [11:0] a, input logic w, input logic [15:0] d);
    integer n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {16'hffff, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
        $display("mismatch pready expected 1 seen %b", pready);
        num_errors++;
        final_report;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task wrChk(input logic [11:0] a, input logic [15:0] d, input logic e);
    begin
      xfer(a, 1'b1, d);
      chk("write error", 32'(e), 32'(err));
    end
  endtask

  task rdChk(input logic [11:0] a, input logic [31:0] expv, input logic e);
    begin
      xfer(a, 1'b0, 16'h0000);
      chk("read data", expv, rd);
      chk("read error", 32'(e), 32'(err));
    end
  endtask

  // Edges until obs[b] rises; returns lim when none came
  task rise(input integer b, input integer lim, output integer n);
    logic prev;
    begin
      n = 0;
      prev = obs[b];
      do
      begin
        @(posedge sys_clk);
        n++;
        if (prev === 1'b0 && obs[b] === 1'b1)
          break;
        prev = obs[b];
      end
      while (n < lim);
    end
  endtask

  // Two settling rises absorb a pending glitchless ratio change
  task period(input integer b, input integer expv);
    integer n;
    begin
      rise(b, 2000, n);
      rise(b, 2000, n);
      rise(b, 2000, n);
      chk("clock period", expv, n);
    end
  endtask

  task opposite(input integer a, input integer b);
    integer n;
    begin
      n = 0;
      repeat (16)
      begin
        @(posedge sys_clk);
        if (obs[a] === obs[b])
          n++;
      end
      chk("pins not inverted", 0, n);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (12) @(posedge sys_clk);
    for (i = 0; i < 13; i++)
    begin
      rdChk(regAddr[i], 32'h0000_0000, 1'b0);
      wrChk(regAddr[i], 16'h9c65 ^ 16'(i), 1'b0);
      rdChk(regAddr[i], {16'h0000, 16'h9c65 ^ 16'(i)}, 1'b0);
    end
    chk("output_zero slew", 32'h0000_000e, 32'(outZeroSlewSetting));
    chk("channel slew", 32'h0000_00c1, 32'({ch4SlewSetting, ch1SlewSetting}));
    // Pattern keeps HCSL and LVDS apart per channel; 1.8 V detect on 3 and 4 with safety set
    chk("diff enables", 32'h0000_1c69,
        32'({safetyLowVoltage, chSupplyDetect, chLvdsEnable, chHcslEnable}));
    for (i = 0; i < 13; i++)
      wrChk(regAddr[i], 16'h0000, 1'b0);
    wrChk(12'h144, 16'hffff, 1'b0);
    rdChk(12'h200, 32'h0000_0000, 1'b1);
    wrChk(12'h066, 16'h0600, 1'b1);
    rdChk(12'h064, 32'h0000_0000, 1'b0);
    // Channel 1 from A, 2 from B, 3 from reference, 4 switched off
    wrChk(12'h140, 16'h000f, 1'b0);
    wrChk(12'h0e0, 16'h0002, 1'b0);
    wrChk(12'h0f8, 16'h4002, 1'b0);
    wrChk(12'h10c, 16'h8002, 1'b0);
    wrChk(12'h120, 16'hc002, 1'b0);
    vcoTick <= 1'b1;
    srcRun <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      wrChk(12'h0bc, 16'((i << 3) | (((i + 1) % 3) << 5)), 1'b0);
      period(0, 2 * (4 + i));
      period(1, 2 * (4 + (i + 1) % 3));
    end
    period(2, 12);
    rise(3, 60, p);
    chk("channel off", 60, p);
    wrChk(12'h0e0, 16'h0101, 1'b0);
    period(0, 1542);
    wrChk(12'h0bc, 16'h0018, 1'b0);
    repeat (10) @(posedge sys_clk);
    rise(0, 100, p);
    chk("prescaler stopped", 100, p);
    wrChk(12'h0bc, 16'h0000, 1'b0);
    wrChk(12'h0e0, 16'h0002, 1'b0);
    wrChk(12'h064, 16'h4000, 1'b0);
    period(3, 6);
    wrChk(12'h138, 16'h1000, 1'b0);
    wrChk(12'h064, 16'h0600, 1'b0);
    period(8, 6);
    wrChk(12'h064, 16'h0400, 1'b0);
    period(8, 10);
    wrChk(12'h138, 16'h0000, 1'b0);
    rise(8, 40, p);
    chk("output_zero buffer off", 40, p);
    // One buffer type per channel: HCSL off on channels 1 and 4 before their pins run
    wrChk(12'h140, 16'h0006, 1'b0);
    // Channel 1 pins: both on, P inverted, then P alone off
    wrChk(12'h0ec, 16'h6800, 1'b0);
    period(4, 8);
    opposite(4, 5);
    wrChk(12'h0ec, 16'h4000, 1'b0);
    period(5, 8);
    rise(4, 40, p);
    chk("ch1 P off", 40, p);
    // Channel 4 pin order is mirrored
    wrChk(12'h064, 16'h0000, 1'b0);
    wrChk(12'h120, 16'h0002, 1'b0);
    wrChk(12'h12c, 16'h7000, 1'b0);
    opposite(6, 7);
    wrChk(12'h12c, 16'h4000, 1'b0);
    period(6, 8);
    rise(7, 40, p);
    chk("ch4 N off", 40, p);
    // Sync hold parks every divider low; a late rise from before the hold must pass first
    wrChk(12'h140, 16'h2006, 1'b0);
    repeat (4) @(posedge sys_clk);
    rise(6, 40, p);
    chk("sync hold", 40, p);
    wrChk(12'h140, 16'h0006, 1'b0);
    period(6, 8);
    final_report;
  end

  // Bound on the whole run
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    $display("mismatch run length expected finish seen timeout");
    num_errors++;
    final_report;
  end
endmodule // output_clock_distribution_test
